// *** verilog/crco_pkg.sv ***
// Constants and types for the counter range and comparison output logic
package crco_pkg;
  localparam int NCNT = 2;
  localparam int NENT = 32;
  localparam int DW = 32;
  localparam int NRNG_W = 6;
  localparam int GEN_W = 16;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STOP_TIME_NS = 1500000;
  localparam int STOP_CYC = STOP_TIME_NS / CLK_PERIOD_NS;
  // Table select codes for the block write port
  localparam logic [3:0] SEL_LO = 4'h0;
  localparam logic [3:0] SEL_HI = 4'h1;
  localparam logic [3:0] SEL_RPAT = 4'h2;
  localparam logic [3:0] SEL_REN = 4'h3;
  localparam logic [3:0] SEL_CV = 4'h4;
  localparam logic [3:0] SEL_SETP = 4'h5;
  localparam logic [3:0] SEL_RSTP = 4'h6;
  localparam logic [3:0] SEL_SETN = 4'h7;
  localparam logic [3:0] SEL_RSTN = 4'h8;
  localparam logic [3:0] SEL_CEN = 4'h9;
  localparam logic [3:0] SEL_NRNG = 4'ha;
  localparam logic [3:0] SEL_GEN = 4'hb;
  // unit_general_setting fields
  localparam int GEN_AND_BIT = 0;
  localparam int GEN_CMP_BIT = 1;
  localparam int GEN_CIRC_BIT = 2;
  localparam logic [15:0] GEN_RESET = 16'h0000;
  localparam logic [NRNG_W-1:0] NRNG_RESET = 6'h00;
  localparam logic [31:0] PAT_OFF = 32'h0000_0000;
  typedef enum logic [1:0] {
    CRCO_RUN  = 2'b01,
    CRCO_HOLD = 2'b10
  } crco_cmp_e;
endpackage : crco_pkg

// *** verilog/crco_cnt_eval.sv ***
// Per-counter range, comparison and duplicate-value evaluation
`timescale 1ns/10ps
module crco_cnt_eval #(
  parameter int N = 32
) (
  input  wire logic                 circ,
  input  wire logic [N-1:0][31:0]   lo,
  input  wire logic [N-1:0][31:0]   hi,
  input  wire logic [N-1:0][31:0]   cv,
  input  wire logic [N-1:0]         cen,
  input  wire logic [31:0]          ref_val,
  input  wire logic [31:0]          cur_val,
  output logic      [N-1:0]         range_act,
  output logic      [N-1:0]         cv_act,
  output logic      [N-1:0]         up_x,
  output logic      [N-1:0]         dn_x,
  output logic                      dup_err
);
  logic [N-1:0] dup_v;

  // Signed order for linear, unsigned for circular counters
  function automatic logic le(input logic [31:0] a, input logic [31:0] b,
                              input logic c);
    le = c ? (a <= b) : ($signed(a) <= $signed(b));
  endfunction : le

  for (genvar i = 0; i < N; i++) begin : g_ent
    always_comb begin
      if (le(lo[i], hi[i], circ))
        range_act[i] = le(lo[i], cur_val, circ)
                       && le(cur_val, hi[i], circ);
      else
        range_act[i] = circ && (le(lo[i], cur_val, circ)
                       || le(cur_val, hi[i], circ));
    end
    assign cv_act[i] = le(cv[i], cur_val, circ);
    assign up_x[i] = !le(cv[i], ref_val, circ) && le(cv[i], cur_val, circ);
    assign dn_x[i] = le(cv[i], ref_val, circ) && !le(cv[i], cur_val, circ);
    always_comb begin
      dup_v[i] = 1'b0;
      for (int j = i + 1; j < N; j++)
        if (cen[i] && cen[j] && cv[i] == cv[j])
          dup_v[i] = 1'b1;
    end
  end

  assign dup_err = |dup_v;
endmodule : crco_cnt_eval

// *** verilog/crco_top.sv ***
// Range and comparison output pattern logic for a two-counter unit
// Behaviour
// - Range active when lower limit <= count <= upper limit.
// - Active state of each range reported per counter to the host.
// - Equal lower and upper limit is legal; active only at that value.
// - Each range has an enable, off by default; disabled ranges ignored.
// - Active enabled range adds its pattern to its counter pattern.
// - Range mode combine bit: 0 ORs, 1 ANDs the counter patterns.
// - AND combining skips counters configured with zero ranges.
// - Both counters with zero ranges give an all-off pattern.
// - Up to 32 comparison values per counter, five words each.
// - Values signed for linear, unsigned for circular counters.
// - On reaching a value, set pattern of the direction sets outputs.
// - On reaching a value, reset pattern of the direction clears outputs.
// - After a target is reached, that counter alone pauses 1.5 ms.
// - After a pause all values passed meanwhile are applied together.
// - Block read or write pauses all counters and holds busy flag.
// - After busy clears, one catch-up comparison in comparison mode.
// - Comparison data rewrite recomputes from new data, drops pause result.
// - Equal enabled comparison values within one counter raise a config error in comparison mode.
// - Set and reset actions of one cycle apply counter 0 first, then counter 1.
// - Set and reset on the same output at one value: reset wins.
// - Range enables can change by block write while counting.
// - Comparison data can change by block write while counting.
// - Pattern is 32 bits; bits 0 and 1 drive the digital outputs.
// - Several active ranges of a counter OR their patterns.
// - Comparison value active when count >= value, reported per counter.
`timescale 1ns/10ps
module crco_top #(
  parameter int STOP_CYC = crco_pkg::STOP_CYC,
  parameter int NENT     = crco_pkg::NENT
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [31:0]       cnt0_val,
  input  wire logic [31:0]       first_counter_val,
  input  wire logic              blk_exec,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_cnt,
  input  wire logic [3:0]        cfg_sel,
  input  wire logic [4:0]        cfg_idx,
  input  wire logic [31:0]       cfg_data,
  output logic      [31:0]       unit_pattern_ff,
  output logic      [1:0]        phys_out_ff,
  output logic      [NENT-1:0]   range_act0_ff,
  output logic      [NENT-1:0]   range_act1_ff,
  output logic      [NENT-1:0]   cv_act0_ff,
  output logic      [NENT-1:0]   cv_act1_ff,
  output logic                   xfer_busy_ff,
  output logic                   cfg_err_ff,
  output logic      [1:0]        cmp_hold_ff,
  output logic      [15:0]       unit_general_setting_ff
);
  localparam int NC = crco_pkg::NCNT;
  localparam int TW = $clog2(STOP_CYC + 1);
  localparam logic [TW-1:0] TMR_LOAD = TW'(STOP_CYC - 1);
  localparam logic [TW-1:0] TMR_ZERO = '0;

  //////////////////////////////////////////////////////////////////////////
  // Tables
  logic [NENT-1:0][31:0]           lo_ff   [NC];
  logic [NENT-1:0][31:0]           hi_ff   [NC];
  logic [NENT-1:0][31:0]           rpat_ff [NC];
  logic [NENT-1:0][31:0]           cv_ff   [NC];
  logic [NENT-1:0][31:0]           setp_ff [NC];
  logic [NENT-1:0][31:0]           rstp_ff [NC];
  logic [NENT-1:0][31:0]           setn_ff [NC];
  logic [NENT-1:0][31:0]           rstn_ff [NC];
  logic [NENT-1:0]                 ren_ff  [NC];
  logic [NENT-1:0]                 cen_ff  [NC];
  logic [crco_pkg::NRNG_W-1:0]     nrng_ff [NC];
  logic [31:0]                     ref_ff  [NC];
  logic [TW-1:0]                   tmr_ff  [NC];
  crco_pkg::crco_cmp_e             st_ff   [NC];
  logic [NC-1:0]                   dirty_ff;
  logic [31:0]                     cur     [NC];
  logic [NENT-1:0]                 ract    [NC];
  logic [NENT-1:0]                 cact    [NC];
  logic [NENT-1:0]                 upx     [NC];
  logic [NENT-1:0]                 dnx     [NC];
  logic [NC-1:0]                   dup;
  logic [NC-1:0]                   run;
  logic [NC-1:0]                   fire;
  logic [NC-1:0]                   hit;
  logic [31:0]                     cpat    [NC];
  logic [31:0]                     nxt_pat;
  logic                            cmp_mode;
  logic                            and_mode;

  assign cur[0] = cnt0_val;
  assign cur[1] = first_counter_val;
  assign cmp_mode = unit_general_setting_ff[crco_pkg::GEN_CMP_BIT];
  assign and_mode = unit_general_setting_ff[crco_pkg::GEN_AND_BIT];

  // Table data, written by the block write instruction at any time
  always_ff @(posedge clk) begin
    if (cfg_wr) begin
      case (cfg_sel)
        crco_pkg::SEL_LO:   lo_ff[cfg_cnt][cfg_idx] <= cfg_data;
        crco_pkg::SEL_HI:   hi_ff[cfg_cnt][cfg_idx] <= cfg_data;
        crco_pkg::SEL_RPAT: rpat_ff[cfg_cnt][cfg_idx] <= cfg_data;
        crco_pkg::SEL_CV:   cv_ff[cfg_cnt][cfg_idx] <= cfg_data;
        crco_pkg::SEL_SETP: setp_ff[cfg_cnt][cfg_idx] <= cfg_data;
        crco_pkg::SEL_RSTP: rstp_ff[cfg_cnt][cfg_idx] <= cfg_data;
        crco_pkg::SEL_SETN: setn_ff[cfg_cnt][cfg_idx] <= cfg_data;
        crco_pkg::SEL_RSTN: rstn_ff[cfg_cnt][cfg_idx] <= cfg_data;
        default: ;
      endcase
    end
  end

  // Enables, range counts and general setting
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int c = 0; c < NC; c++) begin
        ren_ff[c] <= '0;
        cen_ff[c] <= '0;
        nrng_ff[c] <= crco_pkg::NRNG_RESET;
      end
      unit_general_setting_ff <= crco_pkg::GEN_RESET;
    end else if (cfg_wr) begin
      case (cfg_sel)
        crco_pkg::SEL_REN:  ren_ff[cfg_cnt][cfg_idx] <= cfg_data[0];
        crco_pkg::SEL_CEN:  cen_ff[cfg_cnt][cfg_idx] <= cfg_data[0];
        crco_pkg::SEL_NRNG:
          nrng_ff[cfg_cnt] <= cfg_data[crco_pkg::NRNG_W-1:0];
        crco_pkg::SEL_GEN:
          unit_general_setting_ff <= cfg_data[crco_pkg::GEN_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-counter evaluation
  for (genvar c = 0; c < NC; c++) begin : g_cnt
    crco_cnt_eval #(.N(NENT)) u_eval (
      .circ      (unit_general_setting_ff[crco_pkg::GEN_CIRC_BIT + c]),
      .lo        (lo_ff[c]),
      .hi        (hi_ff[c]),
      .cv        (cv_ff[c]),
      .cen       (cen_ff[c]),
      .ref_val   (ref_ff[c]),
      .cur_val   (cur[c]),
      .range_act (ract[c]),
      .cv_act    (cact[c]),
      .up_x      (upx[c]),
      .dn_x      (dnx[c]),
      .dup_err   (dup[c])
    );
    // Counter pattern: OR of active enabled ranges within the count
    always_comb begin
      cpat[c] = crco_pkg::PAT_OFF;
      for (int i = 0; i < NENT; i++)
        if (ract[c][i] && ren_ff[c][i]
            && crco_pkg::NRNG_W'(i) < nrng_ff[c])
          cpat[c] = cpat[c] | rpat_ff[c][i];
    end
    assign run[c] = cmp_mode && !xfer_busy_ff
                    && st_ff[c] == crco_pkg::CRCO_RUN;
    assign fire[c] = run[c] && !dirty_ff[c];
    assign hit[c] = fire[c] && |((upx[c] | dnx[c]) & cen_ff[c]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Comparison pause, reference count and rewrite tracking
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int c = 0; c < NC; c++) begin
        st_ff[c] <= crco_pkg::CRCO_RUN;
        tmr_ff[c] <= TMR_ZERO;
        ref_ff[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NC; c++) begin
        // Reference holds while paused, giving the catch-up later
        if (!cmp_mode || run[c])
          ref_ff[c] <= cur[c];
        case (st_ff[c])
          crco_pkg::CRCO_RUN: begin
            if (hit[c]) begin
              st_ff[c] <= crco_pkg::CRCO_HOLD;
              tmr_ff[c] <= TMR_LOAD;
            end
          end
          crco_pkg::CRCO_HOLD: begin
            if (tmr_ff[c] == TMR_ZERO)
              st_ff[c] <= crco_pkg::CRCO_RUN;
            else
              tmr_ff[c] <= tmr_ff[c] - 1'b1;
          end
          default: st_ff[c] <= crco_pkg::CRCO_RUN;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dirty_ff <= '0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        // New data written wins over the clear in the same cycle
        if (cfg_wr && cfg_cnt == 1'(c) && cfg_sel >= crco_pkg::SEL_CV
            && cfg_sel <= crco_pkg::SEL_CEN)
          dirty_ff[c] <= 1'b1;
        else if (run[c])
          dirty_ff[c] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next unit output pattern
  always_comb begin
    nxt_pat = unit_pattern_ff;
    if (!xfer_busy_ff) begin
      if (!cmp_mode) begin
        if (nrng_ff[0] == '0 && nrng_ff[1] == '0)
          nxt_pat = crco_pkg::PAT_OFF;
        else if (and_mode) begin
          if (nrng_ff[0] == '0)
            nxt_pat = cpat[1];
          else if (nrng_ff[1] == '0)
            nxt_pat = cpat[0];
          else
            nxt_pat = cpat[0] & cpat[1];
        end else begin
          nxt_pat = cpat[0] | cpat[1];
        end
      end else begin
        // Counter 0 then counter 1, each applied to the running result
        for (int c = 0; c < NC; c++)
          for (int i = 0; i < NENT; i++)
            if (fire[c] && cen_ff[c][i]) begin
              if (upx[c][i])
                nxt_pat = (nxt_pat | setp_ff[c][i])
                          & ~rstp_ff[c][i];
              else if (dnx[c][i])
                nxt_pat = (nxt_pat | setn_ff[c][i])
                          & ~rstn_ff[c][i];
            end
      end
    end
  end

  // Output pattern and digital outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      unit_pattern_ff <= crco_pkg::PAT_OFF;
      phys_out_ff <= '0;
    end else begin
      unit_pattern_ff <= nxt_pat;
      phys_out_ff <= nxt_pat[1:0];
    end
  end

  // Status words
  always_ff @(posedge clk) begin
    if (!nrst) begin
      range_act0_ff <= '0;
      range_act1_ff <= '0;
      cv_act0_ff <= '0;
      cv_act1_ff <= '0;
      xfer_busy_ff <= 1'b0;
      cfg_err_ff <= 1'b0;
      cmp_hold_ff <= '0;
    end else begin
      range_act0_ff <= ract[0];
      range_act1_ff <= ract[1];
      cv_act0_ff <= cact[0];
      cv_act1_ff <= cact[1];
      xfer_busy_ff <= blk_exec;
      cfg_err_ff <= cmp_mode && |dup;
      cmp_hold_ff <= {st_ff[1] == crco_pkg::CRCO_HOLD,
                      st_ff[0] == crco_pkg::CRCO_HOLD};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_busy_flag_follows: assert property (
    blk_exec && !cfg_wr |=> xfer_busy_ff)
    else $error("busy flag not set during block instruction");
  a_busy_holds_pattern: assert property (
    xfer_busy_ff |=> $stable(unit_pattern_ff))
    else $error("pattern changed while transfer busy");
  a_hold_lasts: assert property (
    $rose(cmp_hold_ff[0]) |-> cmp_hold_ff[0] [*8])
    else $error("comparison pause ended early");
  a_range_or_combine: assert property (
    !cmp_mode && !and_mode && !xfer_busy_ff
    && (nrng_ff[0] != '0 || nrng_ff[1] != '0) && !cfg_wr
    |=> unit_pattern_ff == $past(cpat[0] | cpat[1]))
    else $error("range OR combine wrong");
  a_and_skips_unused: assert property (
    !cmp_mode && and_mode && !xfer_busy_ff && nrng_ff[0] == '0
    && nrng_ff[1] != '0 && !cfg_wr
    |=> unit_pattern_ff == $past(cpat[1]))
    else $error("unused counter not skipped in AND");
  a_zero_ranges_off: assert property (
    !cmp_mode && !xfer_busy_ff && nrng_ff[0] == '0
    && nrng_ff[1] == '0 && !cfg_wr |=> unit_pattern_ff == '0)
    else $error("pattern not off with zero ranges");
  a_range_limits: assert property (
    !unit_general_setting_ff[crco_pkg::GEN_CIRC_BIT]
    && $signed(lo_ff[0][0]) <= $signed(cnt0_val)
    && $signed(cnt0_val) <= $signed(hi_ff[0][0])
    |=> range_act0_ff[0])
    else $error("range 0 not reported active");
  a_dup_flags_error: assert property (
    cmp_mode && cen_ff[0][0] && cen_ff[0][1]
    && cv_ff[0][0] == cv_ff[0][1] |=> cfg_err_ff)
    else $error("duplicate value not flagged");
  a_phys_bits: assert property (
    phys_out_ff == unit_pattern_ff[1:0])
    else $error("digital outputs differ from pattern");
  a_and_combine: assert property (
    !cmp_mode && and_mode && !xfer_busy_ff && nrng_ff[0] != '0
    && nrng_ff[1] != '0 |=> unit_pattern_ff == $past(cpat[0] & cpat[1]))
    else $error("range AND combine wrong");
  a_pause_holds_ref: assert property (
    cmp_mode && st_ff[0] == crco_pkg::CRCO_HOLD |=> $stable(ref_ff[0]))
    else $error("reference count moved during pause");
  a_rewrite_drops: assert property (
    dirty_ff[0] && run[0] && !fire[1] |=> $stable(unit_pattern_ff))
    else $error("pattern changed on rewrite refresh");
  a_err_only_cmp: assert property (
    !cmp_mode |=> !cfg_err_ff)
    else $error("config error outside comparison mode");

  c_pause_entered: cover property ($rose(cmp_hold_ff[0]));
  c_and_mode_on: cover property (!cmp_mode && and_mode
                                 && unit_pattern_ff != '0);
  c_busy_release: cover property ($fell(xfer_busy_ff));
  c_dup_error: cover property ($rose(cfg_err_ff));
  c_rewrite_drop: cover property (dirty_ff[0] && run[0]);
endmodule : crco_top

// *** dv/crco_host_model.sv ***
// Host side model: block write port and transfer busy level
`timescale 1ns/10ps
module crco_host_model (
  input  wire logic        clk,
  output logic             blk_exec,
  output logic             cfg_wr,
  output logic             cfg_cnt,
  output logic [3:0]       cfg_sel,
  output logic [4:0]       cfg_idx,
  output logic [31:0]      cfg_data
);
  initial begin
    blk_exec = 1'b0;
    cfg_wr   = 1'b0;
    cfg_cnt  = 1'b0;
    cfg_sel  = 4'hf;
    cfg_idx  = 5'h00;
    cfg_data = 32'h0000_0000;
  end

  // One word per edge, strobe held across back to back writes
  task automatic wr(input logic c, input logic [3:0] s, input logic [4:0] i,
                    input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_wr   = 1'b1;
    cfg_cnt  = c;
    cfg_sel  = s;
    cfg_idx  = i;
    cfg_data = d;
  endtask : wr

  // Release the port; data lines no longer hold the last word
  task automatic idle();
    @(posedge clk);
    #1;
    cfg_wr   = 1'b0;
    cfg_idx  = ~cfg_idx;
    cfg_data = ~cfg_data;
  endtask : idle

  // Instruction processing level
  task automatic busy(input logic b);
    @(posedge clk);
    #1;
    blk_exec = b;
  endtask : busy
endmodule : crco_host_model

// *** dv/tb_top.sv ***
// Self-checking testbench for the range and comparison output logic
`timescale 1ns/10ps
module tb_top;
  logic               clk;
  logic               nrst;
  logic [31:0]        cnt0_val;
  logic [31:0]        first_counter_val;
  logic               blk_exec;
  logic               cfg_wr;
  logic               cfg_cnt;
  logic [3:0]         cfg_sel;
  logic [4:0]         cfg_idx;
  logic [31:0]        cfg_data;
  logic [31:0]        unit_pattern_ff;
  logic [1:0]         phys_out_ff;
  logic [31:0]        range_act0_ff;
  logic [31:0]        cv_act0_ff;
  logic [31:0]        range_act1_ff;
  logic [31:0]        cv_act1_ff;
  logic               xfer_busy_ff;
  logic               cfg_err_ff;
  logic [1:0]         cmp_hold_ff;
  logic [15:0]        gen_ff;
  int                 error_cnt;
  int                 n_tests;

  crco_top #(.STOP_CYC(20)) u_dut (
    .clk(clk), .nrst(nrst), .cnt0_val(cnt0_val), .first_counter_val(first_counter_val),
    .blk_exec(blk_exec), .cfg_wr(cfg_wr), .cfg_cnt(cfg_cnt),
    .cfg_sel(cfg_sel), .cfg_idx(cfg_idx), .cfg_data(cfg_data),
    .unit_pattern_ff(unit_pattern_ff), .phys_out_ff(phys_out_ff),
    .range_act0_ff(range_act0_ff), .range_act1_ff(range_act1_ff),
    .cv_act0_ff(cv_act0_ff), .cv_act1_ff(cv_act1_ff),
    .xfer_busy_ff(xfer_busy_ff),
    .cfg_err_ff(cfg_err_ff), .cmp_hold_ff(cmp_hold_ff),
    .unit_general_setting_ff(gen_ff)
  );

  crco_host_model u_host (
    .clk(clk), .blk_exec(blk_exec), .cfg_wr(cfg_wr), .cfg_cnt(cfg_cnt),
    .cfg_sel(cfg_sel), .cfg_idx(cfg_idx), .cfg_data(cfg_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Counts move in clean steps, no fast reversal near a value
  task automatic setc(input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    #1;
    cnt0_val = a;
    first_counter_val = b;
  endtask : setc

  task automatic wait_pat(input logic [31:0] e, input int n);
    int i;
    i = 0;
    while (i < n && unit_pattern_ff !== e) begin
      cyc(1);
      i++;
    end
    chk(unit_pattern_ff, e);
    if (unit_pattern_ff !== e) report_and_stop();
  endtask : wait_pat

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cyc(1);
    chk(unit_pattern_ff, 32'h0000_0000);
    chk({16'h0000, gen_ff}, 32'h0000_0000);
    chk({29'h0, xfer_busy_ff, cmp_hold_ff}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_range();
    u_host.wr(1'b0, crco_pkg::SEL_NRNG, 5'h00, 32'h0000_0002);
    u_host.wr(1'b0, crco_pkg::SEL_LO, 5'h00, 32'hffff_ffec);
    u_host.wr(1'b0, crco_pkg::SEL_HI, 5'h00, 32'hffff_fff6);
    u_host.wr(1'b0, crco_pkg::SEL_RPAT, 5'h00, 32'h0000_0001);
    u_host.wr(1'b0, crco_pkg::SEL_REN, 5'h00, 32'h0000_0001);
    u_host.wr(1'b0, crco_pkg::SEL_LO, 5'h01, 32'h0000_0005);
    u_host.wr(1'b0, crco_pkg::SEL_HI, 5'h01, 32'h0000_0005);
    u_host.wr(1'b0, crco_pkg::SEL_RPAT, 5'h01, 32'h0000_0006);
    u_host.idle();
    setc(32'hffff_ffec, 32'h0000_0000);
    wait_pat(32'h0000_0001, 8);
    setc(32'hffff_ffeb, 32'h0000_0000);
    wait_pat(32'h0000_0000, 8);
    setc(32'h0000_0005, 32'h0000_0000);
    cyc(4);
    chk(range_act0_ff, 32'h0000_0002);
    chk(unit_pattern_ff, 32'h0000_0000);
    u_host.wr(1'b0, crco_pkg::SEL_REN, 5'h01, 32'h0000_0001);
    u_host.idle();
    wait_pat(32'h0000_0006, 8);
    setc(32'h0000_0006, 32'h0000_0000);
    wait_pat(32'h0000_0000, 8);
    u_host.wr(1'b0, crco_pkg::SEL_HI, 5'h00, 32'h0000_000a);
    u_host.idle();
    setc(32'h0000_0005, 32'h0000_0032);
    wait_pat(32'h0000_0007, 8);
  endtask : t_range

  task automatic t_combine();
    u_host.wr(1'b1, crco_pkg::SEL_NRNG, 5'h00, 32'h0000_0001);
    u_host.wr(1'b1, crco_pkg::SEL_LO, 5'h00, 32'h0000_0000);
    u_host.wr(1'b1, crco_pkg::SEL_HI, 5'h00, 32'h0000_0064);
    u_host.wr(1'b1, crco_pkg::SEL_RPAT, 5'h00, 32'h0000_0003);
    u_host.wr(1'b1, crco_pkg::SEL_REN, 5'h00, 32'h0000_0001);
    u_host.idle();
    cyc(4);
    chk(unit_pattern_ff, 32'h0000_0007);
    chk({30'h0, phys_out_ff}, 32'h0000_0003);
    chk(range_act1_ff, 32'h0000_0001);
    u_host.wr(1'b0, crco_pkg::SEL_GEN, 5'h00, 32'h0000_0001);
    u_host.idle();
    wait_pat(32'h0000_0003, 8);
    setc(32'h0000_0005, 32'h0000_00c8);
    wait_pat(32'h0000_0000, 8);
    u_host.wr(1'b1, crco_pkg::SEL_NRNG, 5'h00, 32'h0000_0000);
    u_host.idle();
    wait_pat(32'h0000_0007, 8);
    u_host.wr(1'b0, crco_pkg::SEL_NRNG, 5'h00, 32'h0000_0000);
    u_host.idle();
    wait_pat(32'h0000_0000, 8);
  endtask : t_combine

  task automatic t_cmp();
    setc(32'hffff_fff6, 32'h0000_00c8);
    u_host.wr(1'b0, crco_pkg::SEL_GEN, 5'h00, 32'h0000_0002);
    u_host.wr(1'b0, crco_pkg::SEL_CV, 5'h00, 32'hffff_fffb);
    u_host.wr(1'b0, crco_pkg::SEL_SETP, 5'h00, 32'h0000_0009);
    u_host.wr(1'b0, crco_pkg::SEL_RSTP, 5'h00, 32'h0000_0001);
    u_host.wr(1'b0, crco_pkg::SEL_SETN, 5'h00, 32'h0000_0000);
    u_host.wr(1'b0, crco_pkg::SEL_RSTN, 5'h00, 32'h0000_0008);
    u_host.wr(1'b0, crco_pkg::SEL_CEN, 5'h00, 32'h0000_0001);
    u_host.wr(1'b1, crco_pkg::SEL_CV, 5'h00, 32'h0000_00fa);
    u_host.wr(1'b1, crco_pkg::SEL_SETP, 5'h00, 32'h0000_0010);
    u_host.wr(1'b1, crco_pkg::SEL_RSTP, 5'h00, 32'h0000_0000);
    u_host.wr(1'b1, crco_pkg::SEL_SETN, 5'h00, 32'h0000_0000);
    u_host.wr(1'b1, crco_pkg::SEL_RSTN, 5'h00, 32'h0000_0000);
    u_host.wr(1'b1, crco_pkg::SEL_CEN, 5'h00, 32'h0000_0001);
    u_host.idle();
    cyc(3);
    setc(32'h0000_0000, 32'h0000_00c8);
    wait_pat(32'h0000_0008, 8);
    chk({31'h0, cv_act0_ff[0]}, 32'h0000_0001);
    cyc(2);
    chk({31'h0, cmp_hold_ff[0]}, 32'h0000_0001);
    setc(32'hffff_fff6, 32'h0000_012c);
    wait_pat(32'h0000_0018, 8);
    chk({31'h0, cv_act1_ff[0]}, 32'h0000_0001);
    wait_pat(32'h0000_0010, 40);
    chk({30'h0, cmp_hold_ff}, 32'h0000_0002);
  endtask : t_cmp

  task automatic t_busy();
    cyc(30);
    u_host.busy(1'b1);
    cyc(2);
    chk({31'h0, xfer_busy_ff}, 32'h0000_0001);
    setc(32'h0000_0000, 32'h0000_012c);
    cyc(4);
    chk(unit_pattern_ff, 32'h0000_0010);
    u_host.busy(1'b0);
    wait_pat(32'h0000_0018, 8);
    cyc(30);
    u_host.busy(1'b1);
    setc(32'hffff_fff6, 32'h0000_012c);
    u_host.wr(1'b0, crco_pkg::SEL_CV, 5'h00, 32'hffff_fffb);
    u_host.idle();
    u_host.busy(1'b0);
    cyc(8);
    chk(unit_pattern_ff, 32'h0000_0018);
  endtask : t_busy

  task automatic t_dup();
    u_host.wr(1'b0, crco_pkg::SEL_CV, 5'h01, 32'hffff_fffb);
    u_host.wr(1'b0, crco_pkg::SEL_CEN, 5'h01, 32'h0000_0001);
    u_host.idle();
    cyc(3);
    chk({31'h0, cfg_err_ff}, 32'h0000_0001);
    u_host.wr(1'b0, crco_pkg::SEL_CV, 5'h01, 32'h0000_0007);
    u_host.idle();
    cyc(3);
    chk({31'h0, cfg_err_ff}, 32'h0000_0000);
  endtask : t_dup

  // Circular counter: unsigned limits, range wraps past zero
  task automatic t_circ();
    u_host.wr(1'b0, crco_pkg::SEL_HI, 5'h01, 32'h8000_0000);
    u_host.wr(1'b0, crco_pkg::SEL_NRNG, 5'h00, 32'h0000_0002);
    u_host.wr(1'b0, crco_pkg::SEL_GEN, 5'h00, 32'h0000_0004);
    u_host.idle();
    setc(32'h0000_0100, 32'h0000_012c);
    wait_pat(32'h0000_0006, 8);
    chk({30'h0, range_act0_ff[1:0]}, 32'h0000_0002);
  endtask : t_circ

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    n_tests   = 0;
    nrst      = 1'b0;
    cnt0_val  = 32'h0000_0000;
    first_counter_val  = 32'h0000_0000;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_range();
    t_combine();
    t_cmp();
    t_busy();
    t_dup();
    t_circ();
    report_and_stop();
  end
endmodule : tb_top
